// ### design/ssf_params.svh
// constants for the sensor status flag register
`ifndef SSF_PARAMS_SVH
`define SSF_PARAMS_SVH
`define SSF_STATUS_ADDR 8'h18
`define SSF_CHAN_HI 15
`define SSF_CHAN_LO 14
`define SSF_BIT_UR 13
`define SSF_BIT_OR 12
`define SSF_BIT_WD 11
`define SSF_BIT_AH 10
`define SSF_BIT_AL 9
`define SSF_BIT_ZC 8
`define SSF_BIT_RESULT_READY_FLAG 6
`define SSF_EN_UR 7
`define SSF_EN_OR 6
`define SSF_EN_WD 5
`define SSF_EN_AH 4
`define SSF_EN_AL 3
`define SSF_EN_ZC 2
`define SSF_EN_RESULT_READY_FLAG 0
`define SSF_STATUS_RESET 16'h0000
`endif

// ### design/ssf_pkg.sv
// types for the sensor status flag register
package ssf_pkg;
  // error event bundle, one bit per error type
  typedef struct packed {
    logic underRange;
    logic overRange;
    logic timeout;
    logic ampHigh;
    logic ampLow;
    logic zeroCount;
  } ssf_err_t;
  // latch state of the error group
  typedef enum logic [0:0] {
    SSF_IDLE = 1'b0,
    SSF_HELD = 1'b1
  } ssf_state_t;
endpackage : ssf_pkg

// ### design/ssf_pending_if.sv
// interface carrying per-channel pending result traffic
`timescale 1ns/1ns
interface ssf_pending_if #(parameter int NCH = 4);
  logic [3:0] convDone; // conversion finished, per channel
  logic [3:0] dataRead; // result word read, per channel
  logic [3:0] pending; // unread result flags
  modport tracker (input convDone, input dataRead, output pending);
  modport owner (output convDone, output dataRead, input pending);
endinterface : ssf_pending_if

// ### design/ssf_pending_tracker.sv
// per-channel unread result flags
`timescale 1ns/1ns
module ssf_pending_tracker #(
  parameter int NCH = 4
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // channel traffic
  ssf_pending_if.tracker pif
);
  ////////////////////////////////////////////////////////////////////
  // one flag per channel; set wins over a read in the same cycle
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : gCh
      logic flag;
      always_ff @(posedge mclk) begin
        if (rst || g >= NCH) begin
          flag <= 1'b0;
        end else if (pif.convDone[g]) begin
          flag <= 1'b1;
        end else if (pif.dataRead[g]) begin
          flag <= 1'b0;
        end
      end
      assign pif.pending[g] = flag;
    end
  endgenerate
endmodule : ssf_pending_tracker

// ### design/ssf_status_reg.sv
// read-clear status word of the inductive sensor converter
`timescale 1ns/1ns
`include "ssf_params.svh"
module ssf_status_reg #(
  parameter int NCH = 4 // 2 or 4 channels
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // conversion core events
  input wire ssf_pkg::ssf_err_t errEvent,
  input wire logic [1:0] errChannel,
  input wire logic [3:0] convDone,
  input wire logic sequenceMode,
  input wire logic [3:0] activeChannels,
  // error configuration word
  input wire logic [15:0] errorConfig,
  // register read side
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [3:0] dataRegRead,
  output logic [15:0] statusData,
  output logic interrupt_out_n
);
  ////////////////////////////////////////////////////////////////////
  // decode and qualification
  function automatic logic is_status(input logic [7:0] a);
    return a == `SSF_STATUS_ADDR;
  endfunction : is_status

  logic statusRead; // host read of the status word
  logic [5:0] rawErr; // errors from the core
  logic [5:0] errEn; // report enables
  logic [5:0] qualErr; // enabled errors only
  logic [5:0] errFlags; // latched error flags
  logic [1:0] srcChan; // latched source channel
  logic chanOk; // source channel exists in variant
  logic srcRead; // source channel result read
  logic result_ready_flag; // ready flag
  logic [3:0] seqSeen; // sequence channels completed
  logic [3:0] liveMask; // channels present in variant
  logic [3:0] doneMasked; // completions of live channels
  logic [3:0] next_seqSeen; // sequence accumulation
  logic readyEvent; // qualifying ready event
  ssf_pkg::ssf_state_t errState; // error group held or not

  assign statusRead = regRead && is_status(regAddr);
  assign liveMask = (NCH > 2) ? 4'hf : 4'h3;
  assign doneMasked = convDone & liveMask;
  assign chanOk = (NCH > 2) || !errChannel[1];
  assign rawErr = {errEvent.underRange, errEvent.overRange, errEvent.timeout,
                   errEvent.ampHigh, errEvent.ampLow, errEvent.zeroCount};
  assign errEn = {errorConfig[`SSF_EN_UR], errorConfig[`SSF_EN_OR], errorConfig[`SSF_EN_WD],
                  errorConfig[`SSF_EN_AH], errorConfig[`SSF_EN_AL], errorConfig[`SSF_EN_ZC]};
  assign qualErr = chanOk ? (rawErr & errEn) : 6'h00;
  assign srcRead = regRead && dataRegRead[srcChan];

  ////////////////////////////////////////////////////////////////////
  // error flags: new error wins over a clearing read
  always_ff @(posedge mclk) begin
    if (rst) begin
      errFlags <= 6'h00;
    end else if (|qualErr) begin
      // merge unless the held group is being released now
      errFlags <= ((statusRead || srcRead) ? 6'h00 : errFlags) | qualErr;
    end else if (statusRead || srcRead) begin
      errFlags <= 6'h00;
    end
  end

  // source channel tracks the latest reported error
  always_ff @(posedge mclk) begin
    if (rst) begin
      srcChan <= 2'h0;
    end else if (|qualErr) begin
      srcChan <= errChannel;
    end else if (statusRead || srcRead) begin
      srcChan <= 2'h0;
    end
  end

  // held state of the error group
  always_ff @(posedge mclk) begin
    if (rst) begin
      errState <= ssf_pkg::SSF_IDLE;
    end else begin
      case (errState)
        ssf_pkg::SSF_IDLE: if (|qualErr) errState <= ssf_pkg::SSF_HELD;
        ssf_pkg::SSF_HELD: if ((statusRead || srcRead) && !(|qualErr)) errState <= ssf_pkg::SSF_IDLE;
        default: errState <= ssf_pkg::SSF_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // data ready: per conversion, or once per full sequence
  always_comb begin
    next_seqSeen = seqSeen | doneMasked;
    readyEvent = 1'b0;
    if (!sequenceMode) begin
      readyEvent = |doneMasked;
    end else if ((next_seqSeen & activeChannels & liveMask) == (activeChannels & liveMask)
                 && |(activeChannels & liveMask)) begin
      readyEvent = 1'b1;
      next_seqSeen = 4'h0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst || !sequenceMode) begin
      seqSeen <= 4'h0;
    end else begin
      seqSeen <= next_seqSeen;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      result_ready_flag <= 1'b0;
    end else if (readyEvent && errorConfig[`SSF_EN_RESULT_READY_FLAG]) begin
      result_ready_flag <= 1'b1;
    end else if (statusRead) begin
      result_ready_flag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // unread flags
  ssf_pending_if #(.NCH(NCH)) pend ();
  assign pend.convDone = doneMasked;
  assign pend.dataRead = regRead ? dataRegRead : 4'h0;
  ssf_pending_tracker #(.NCH(NCH)) uPending (
    .mclk(mclk),
    .rst(rst),
    .pif(pend.tracker)
  );

  ////////////////////////////////////////////////////////////////////
  // status word image, registered
  always_ff @(posedge mclk) begin
    if (rst) begin
      statusData <= `SSF_STATUS_RESET;
    end else begin
      statusData <= {srcChan, errFlags, 1'b0, result_ready_flag, 2'b00,
                     pend.pending[0], pend.pending[1], pend.pending[2], pend.pending[3]};
    end
  end

  // interrupt low while any error flag or the ready flag stands; unread flags do not drive it
  always_ff @(posedge mclk) begin
    if (rst) begin
      interrupt_out_n <= 1'b1;
    end else begin
      interrupt_out_n <= !((|errFlags) || result_ready_flag);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // checks
  property p_err_latch;
    @(posedge mclk) disable iff (rst) (errEvent.underRange && errorConfig[`SSF_EN_UR] && chanOk)
      |=> errFlags[5] ##1 statusData[`SSF_BIT_UR];
  endproperty
  a_err_latch: assert property (p_err_latch) else $error("under-range not latched");
  property p_masked;
    @(posedge mclk) disable iff (rst) (!errorConfig[`SSF_EN_ZC] && !errFlags[0]) |=> !errFlags[0];
  endproperty
  a_masked: assert property (p_masked) else $error("masked zero count reported");
  property p_clear;
    @(posedge mclk) disable iff (rst) (statusRead && !(|qualErr)) |=> (errFlags == 6'h00);
  endproperty
  a_clear: assert property (p_clear) else $error("status read did not clear errors");
  property p_hold;
    @(posedge mclk) disable iff (rst) (!statusRead && !srcRead && !(|qualErr)) |=> $stable(errFlags) && $stable(srcChan);
  endproperty
  a_hold: assert property (p_hold) else $error("error group changed without cause");
  property p_chan;
    @(posedge mclk) disable iff (rst) (|qualErr) |=> ##1 statusData[15:14] == $past(errChannel, 2);
  endproperty
  a_chan: assert property (p_chan) else $error("wrong source channel");
  property p_rsvd;
    @(posedge mclk) disable iff (rst) statusData[7] == 1'b0 && statusData[5:4] == 2'b00;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
  property p_result_ready_flag_en;
    @(posedge mclk) disable iff (rst) (!errorConfig[`SSF_EN_RESULT_READY_FLAG] && !result_ready_flag) |=> !result_ready_flag;
  endproperty
  a_result_ready_flag_en: assert property (p_result_ready_flag_en) else $error("ready set while disabled");
  property p_result_ready_flag_clr;
    @(posedge mclk) disable iff (rst) (statusRead && !readyEvent) |=> !result_ready_flag;
  endproperty
  a_result_ready_flag_clr: assert property (p_result_ready_flag_clr) else $error("ready not cleared by read");
  property p_pend;
    @(posedge mclk) disable iff (rst) doneMasked[0] |=> pend.pending[0] ##1 statusData[3];
  endproperty
  a_pend: assert property (p_pend) else $error("unread flag not set");
  property p_var;
    @(posedge mclk) disable iff (rst) (NCH == 2) |-> statusData[1:0] == 2'b00;
  endproperty
  a_var: assert property (p_var) else $error("absent channel reported");
  c_err: cover property (@(posedge mclk) disable iff (rst) (|qualErr) ##1 statusRead);
  c_seq: cover property (@(posedge mclk) disable iff (rst) sequenceMode && readyEvent);
  c_src: cover property (@(posedge mclk) disable iff (rst) errState == ssf_pkg::SSF_HELD && srcRead);
endmodule : ssf_status_reg

// ### verification/ssf_host_model.sv
// host model issuing register reads to the status block
`timescale 1ns/1ns
module ssf_host_model (
  // clock
  input wire logic mclk,
  // read requests
  output logic regRead,
  output logic [7:0] regAddr,
  output logic [3:0] dataRegRead
);
  // channels whose drive current the host has lowered
  logic [3:0] driveCut;
  // bus idle from time zero, address parked off the status word
  initial begin
    regRead = 1'b0;
    regAddr = 8'hff;
    dataRegRead = 4'h0;
    driveCut = 4'h0;
  end
  ////////////////////////////////////////////////////////////////
  // amplitude high seen: lower drive of the channel named in bits 15:14
  task automatic easeDrive(input logic [15:0] word);
    if (word[10]) begin
      driveCut[word[15:14]] = 1'b1;
    end
  endtask : easeDrive
  ////////////////////////////////////////////////////////////////
  // one-cycle read; chSel one-hot picks a result word, zero for status
  task automatic hostRead(input logic [7:0] addr, input logic [3:0] chSel);
    @(negedge mclk);
    regRead = 1'b1;
    regAddr = addr;
    dataRegRead = chSel;
    @(negedge mclk);
    regRead = 1'b0;
    regAddr = 8'hff;
    dataRegRead = 4'h0;
  endtask : hostRead
endmodule : ssf_host_model

// ### verification/sensor_status_flag_register_tb_top.sv
// self-checking bench for the status flag register
`timescale 1ns/1ns
module sensor_status_flag_register_tb_top;
  // clock and reset
  logic mclk = 1'b0;
  logic rst;
  // core events and configuration
  ssf_pkg::ssf_err_t errEvent;
  logic [1:0] errChannel;
  logic [3:0] convDone;
  logic sequenceMode;
  logic [3:0] activeChannels;
  logic [15:0] errorConfig;
  // read side
  logic regRead;
  logic [7:0] regAddr;
  logic [3:0] dataRegRead;
  logic [15:0] statusData;
  logic interrupt_out_n;
  // two-channel variant outputs
  logic [15:0] varStatus;
  logic varInt_n;
  // bookkeeping
  int nErrors = 0;
  int nCompared = 0;
  // 100 MHz clock
  always #5 mclk = ~mclk;
  ssf_status_reg #(.NCH(4)) dut_u (.mclk(mclk), .rst(rst), .errEvent(errEvent), .errChannel(errChannel),
    .convDone(convDone), .sequenceMode(sequenceMode), .activeChannels(activeChannels),
    .errorConfig(errorConfig), .regRead(regRead), .regAddr(regAddr), .dataRegRead(dataRegRead),
    .statusData(statusData), .interrupt_out_n(interrupt_out_n));
  // two-channel variant on the same stimulus
  ssf_status_reg #(.NCH(2)) dut2_u (.mclk(mclk), .rst(rst), .errEvent(errEvent), .errChannel(errChannel),
    .convDone(convDone), .sequenceMode(sequenceMode), .activeChannels(activeChannels),
    .errorConfig(errorConfig), .regRead(regRead), .regAddr(regAddr), .dataRegRead(dataRegRead),
    .statusData(varStatus), .interrupt_out_n(varInt_n));
  ssf_host_model host_u (.mclk(mclk), .regRead(regRead), .regAddr(regAddr), .dataRegRead(dataRegRead));
  ////////////////////////////////////////////////////////////////
  // compare status word and interrupt level
  task automatic check(input logic [15:0] expWord, input logic expInt);
    nCompared++;
    if (statusData !== expWord || interrupt_out_n !== expInt) begin
      nErrors++;
      $display("mismatch at %0t: got %h/%h expected %h/%h", $time, statusData, interrupt_out_n, expWord, expInt);
    end
  endtask : check
  // compare the two-channel variant
  task automatic checkVar(input logic [15:0] expWord, input logic expInt);
    nCompared++;
    if (varStatus !== expWord || varInt_n !== expInt) begin
      nErrors++;
      $display("mismatch at %0t: variant got %h/%h expected %h/%h", $time, varStatus, varInt_n, expWord, expInt);
    end
  endtask : checkVar
  // one-cycle event pulse, then wait until the image is settled
  task automatic pulse(input logic [5:0] err, input logic [1:0] ch, input logic [3:0] done);
    @(negedge mclk);
    errEvent = err;
    errChannel = ch;
    convDone = done;
    @(negedge mclk);
    errEvent = '0;
    convDone = 4'h0;
    repeat (2) @(negedge mclk);
  endtask : pulse
  // read then let the image catch up
  task automatic rd(input logic [7:0] addr, input logic [3:0] chSel);
    host_u.hostRead(addr, chSel);
    repeat (2) @(negedge mclk);
  endtask : rd
  ////////////////////////////////////////////////////////////////
  // each error type masked, then enabled, held, cleared by status read
  task automatic testErrors;
    logic [15:0] expWord;
    for (int i = 0; i < 6; i++) begin
      errorConfig = 16'h00fc ^ (16'h0080 >> i);
      pulse(6'h20 >> i, 2'(i % 4), 4'h0);
      check(16'h0000, 1'b1);
      errorConfig = 16'h0080 >> i;
      pulse(6'h20 >> i, 2'(i % 4), 4'h0);
      expWord = {2'(i % 4), 14'h0000} | (16'h2000 >> i);
      repeat (4) @(negedge mclk);
      check(expWord, 1'b0);
      host_u.easeDrive(statusData);
      rd(8'h18, 4'h0);
      check(16'h0000, 1'b1);
    end
    // only the amplitude high error on channel 3 asks for less drive
    nCompared++;
    if (host_u.driveCut !== 4'h8) begin
      nErrors++;
      $display("mismatch at %0t: got %h expected %h", $time, host_u.driveCut, 4'h8);
    end
  endtask : testErrors
  // only the source channel's result read clears the error group
  task automatic testDataClear;
    errorConfig = 16'h00fc;
    pulse(6'h02, 2'd3, 4'h0);
    rd(8'hff, 4'h1);
    check(16'hc200, 1'b0);
    rd(8'hff, 4'h8);
    check(16'h0000, 1'b1);
  endtask : testDataClear
  // single channel ready, its enable, unread flag life cycle
  task automatic testReady;
    errorConfig = 16'h0000;
    sequenceMode = 1'b0;
    activeChannels = 4'h2;
    pulse(6'h00, 2'd0, 4'h2);
    check(16'h0004, 1'b1);
    errorConfig = 16'h0001;
    pulse(6'h00, 2'd0, 4'h2);
    check(16'h0044, 1'b0);
    rd(8'h18, 4'h0);
    check(16'h0004, 1'b1);
    rd(8'hff, 4'h2);
    check(16'h0000, 1'b1);
  endtask : testReady
  // sequence ready only after every active channel
  task automatic testSequence;
    sequenceMode = 1'b1;
    activeChannels = 4'h5;
    pulse(6'h00, 2'd0, 4'h1);
    check(16'h0008, 1'b1);
    pulse(6'h00, 2'd0, 4'h4);
    check(16'h004a, 1'b0);
    rd(8'h18, 4'h0);
    rd(8'hff, 4'h1);
    rd(8'hff, 4'h4);
    check(16'h0000, 1'b1);
  endtask : testSequence
  // new error and clearing status read in one cycle: the error wins
  task automatic testCollide;
    errorConfig = 16'h00fc;
    pulse(6'h20, 2'd0, 4'h0);
    check(16'h2000, 1'b0);
    checkVar(16'h2000, 1'b0);
    fork
      pulse(6'h01, 2'd2, 4'h0);
      rd(8'h18, 4'h0);
    join
    check(16'h8100, 1'b0);
    checkVar(16'h0000, 1'b1);
    rd(8'h18, 4'h0);
    check(16'h0000, 1'b1);
  endtask : testCollide
  // two-channel variant drops channels 2 and 3; errors merge
  task automatic testVariant;
    errorConfig = 16'h00fd;
    sequenceMode = 1'b0;
    pulse(6'h20, 2'd3, 4'hc);
    check(16'he043, 1'b0);
    checkVar(16'h0000, 1'b1);
    pulse(6'h10, 2'd1, 4'h2);
    check(16'h7047, 1'b0);
    checkVar(16'h5044, 1'b0);
    rd(8'h18, 4'h0);
    rd(8'hff, 4'h2);
    rd(8'hff, 4'h4);
    rd(8'hff, 4'h8);
    check(16'h0000, 1'b1);
    checkVar(16'h0000, 1'b1);
  endtask : testVariant
  ////////////////////////////////////////////////////////////////
  // verdict and end of run
  task automatic wrapUp;
    $display("errors %0d compared %0d", nErrors, nCompared);
    if (nErrors == 0 && nCompared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrapUp
  // hang guard
  initial begin
    #200000;
    nErrors++;
    wrapUp();
  end
  // main sequence
  initial begin
    rst = 1'b1;
    errEvent = '0;
    errChannel = 2'd0;
    convDone = 4'h0;
    sequenceMode = 1'b0;
    activeChannels = 4'h1;
    errorConfig = 16'h0000;
    repeat (16) @(negedge mclk);
    check(16'h0000, 1'b1);
    rst = 1'b0;
    repeat (2) @(negedge mclk);
    check(16'h0000, 1'b1);
    testErrors();
    testDataClear();
    testReady();
    testSequence();
    testCollide();
    testVariant();
    wrapUp();
  end
endmodule : sensor_status_flag_register_tb_top
